/* File: inc/rsbie_pkg.sv */
/*
 * Shared constants and types for the receive slip buffer interrupt block:
 * register map, field positions, reset values and buffer geometry.
 * Assumes a single 25 MHz clock domain and a 32-bit Avalon-MM register bus.
 */
package rsbie_pkg;

	// Register byte offsets on the Avalon-MM bus
	localparam logic [3:0] RSBIE_OFS_ENABLE = 4'h0;
	localparam logic [3:0] RSBIE_OFS_STATUS = 4'h4;
	localparam logic [3:0] RSBIE_OFS_LEVEL  = 4'h8;

	// Field positions shared by the enable and status registers
	localparam int RSBIE_BIT_FULL  = 2;
	localparam int RSBIE_BIT_EMPTY = 1;
	localparam int RSBIE_BIT_SLIP  = 0;
	localparam int RSBIE_EVT_W     = 3;

	// Values after reset
	localparam logic [2:0]  RSBIE_ENABLE_RST = 3'h0;
	localparam logic [2:0]  RSBIE_STATUS_RST = 3'h0;
	localparam logic [31:0] RSBIE_RDATA_RST  = 32'h0000_0000;

	// Slip buffer geometry: two frames of 8-bit timeslots
	localparam int         RSBIE_DATA_W = 8;
	localparam int         RSBIE_PTR_W  = 6;
	localparam logic [5:0] RSBIE_FRAME  = 6'h18;
	localparam logic [5:0] RSBIE_DEPTH  = 6'h30;

	// Slip events, laid out like the enable and status fields
	typedef struct packed {
		logic full;
		logic empty;
		logic slip;
	} rsbie_evt_t;

	// Register bus request as seen by the decoder
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [3:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} rsbie_req_t;

endpackage : rsbie_pkg

/* File: hdl/rsbie_sticky.sv */
/*
 * Sticky status bits: hardware sets, software clears by writing one.
 * Assumes set and clear strobes are one-cycle pulses on sys_clk_i.
 */
`timescale 1ns/1ns
module rsbie_sticky
	import rsbie_pkg::*;
(
	input  wire logic             sys_clk_i,
	input  wire logic             rst_n_i,
	input  wire rsbie_evt_t       set_i,
	input  wire logic [2:0]       clr_i,
	output logic      [2:0]       sts_o
);

	logic [2:0] sts_q;
	logic [2:0] sts_d;

	// Set wins over a clear in the same cycle
	always_comb begin
		sts_d = (sts_q & ~clr_i) | set_i;
	end

	// Status storage
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sts_q <= RSBIE_STATUS_RST;
		end else begin
			sts_q <= sts_d;
		end
	end

	assign sts_o = sts_q;

endmodule : rsbie_sticky

/* File: hdl/rsbie_slip_buf.sv */
/*
 * Two-frame receive slip buffer. Writing while full drops the oldest frame;
 * reading while empty replays the last frame read. Never stalls either side.
 * Assumes write and read strobes are synchronous to sys_clk_i.
 */
`timescale 1ns/1ns
module rsbie_slip_buf
	import rsbie_pkg::*;
(
	input  wire logic                     sys_clk_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     wr_i,
	input  wire logic [RSBIE_DATA_W-1:0]  wdata_i,
	input  wire logic                     rd_i,
	output logic      [RSBIE_DATA_W-1:0]  rdata_o,
	output logic      [RSBIE_PTR_W-1:0]   level_o,
	output rsbie_evt_t                    evt_o
);

	logic [RSBIE_DATA_W-1:0] mem_q [RSBIE_DEPTH];
	logic [RSBIE_DATA_W-1:0] mem_d [RSBIE_DEPTH];
	logic [RSBIE_PTR_W-1:0]  rp_q, rp_d, wp_q, wp_d, cnt_q, cnt_d;
	logic [RSBIE_DATA_W-1:0] rdata_q, rdata_d;
	rsbie_evt_t              evt_d;

	// Pointer advance modulo the buffer depth
	function automatic logic [RSBIE_PTR_W-1:0] ptr_add(input logic [RSBIE_PTR_W-1:0] p,
		input logic [RSBIE_PTR_W-1:0] n);
		logic [RSBIE_PTR_W:0] s;
		s = {1'b0, p} + {1'b0, n};
		if (s >= {1'b0, RSBIE_DEPTH}) begin
			s = s - {1'b0, RSBIE_DEPTH};
		end
		return s[RSBIE_PTR_W-1:0];
	endfunction : ptr_add

	// Read is served before write within a cycle
	always_comb begin
		mem_d   = mem_q;
		rp_d    = rp_q;
		wp_d    = wp_q;
		cnt_d   = cnt_q;
		rdata_d = rdata_q;
		evt_d   = '0;
		if (rd_i) begin
			if (cnt_d == '0) begin
				rp_d        = ptr_add(rp_d, RSBIE_DEPTH - RSBIE_FRAME);
				cnt_d       = RSBIE_FRAME;
				evt_d.empty = 1'b1;
				evt_d.slip  = 1'b1;
			end
			rdata_d = mem_q[rp_d];
			rp_d    = ptr_add(rp_d, 6'h01);
			cnt_d   = cnt_d - 6'h01;
		end
		if (wr_i) begin
			if (cnt_d == RSBIE_DEPTH) begin
				rp_d       = ptr_add(rp_d, RSBIE_FRAME);
				cnt_d      = cnt_d - RSBIE_FRAME;
				evt_d.full = 1'b1;
				evt_d.slip = 1'b1;
			end
			mem_d[wp_d] = wdata_i;
			wp_d        = ptr_add(wp_d, 6'h01);
			cnt_d       = cnt_d + 6'h01;
		end
	end

	// Buffer state registers
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < RSBIE_DEPTH; i++) begin
				mem_q[i] <= '0;
			end
			rp_q    <= '0;
			wp_q    <= '0;
			cnt_q   <= '0;
			rdata_q <= '0;
		end else begin
			mem_q   <= mem_d;
			rp_q    <= rp_d;
			wp_q    <= wp_d;
			cnt_q   <= cnt_d;
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o = rdata_q;
	assign level_o = cnt_q;
	assign evt_o   = evt_d;

endmodule : rsbie_slip_buf

/* File: hdl/rsbie_top.sv */
/*
 * Receive slip buffer with interrupt enable, sticky status and one level
 * interrupt, reached over an Avalon-MM slave with waitrequest.
 * Assumes one 25 MHz clock, asynchronous active-low reset, and a bus
 * master that holds each request until it samples waitrequest low.
 */
`timescale 1ns/1ns
module rsbie_top
	import rsbie_pkg::*;
(
	input  wire logic                     sys_clk_i,
	input  wire logic                     rst_n_i,
	input  wire logic [3:0]               avs_address_i,
	input  wire logic                     avs_read_i,
	input  wire logic                     avs_write_i,
	input  wire logic [31:0]              avs_writedata_i,
	input  wire logic [3:0]               avs_byteenable_i,
	output logic      [31:0]              avs_readdata_o,
	output logic                          avs_waitrequest_o,
	input  wire logic                     line_wr_i,
	input  wire logic [RSBIE_DATA_W-1:0]  line_data_i,
	input  wire logic                     sys_rd_i,
	output logic      [RSBIE_DATA_W-1:0]  sys_data_o,
	output logic                          irq_o
);

	rsbie_req_t              req;
	rsbie_evt_t              evt;
	logic [RSBIE_PTR_W-1:0]  level;
	logic [2:0]              sts;
	logic [2:0]              w1c;

	logic                    ack_q;
	logic                    ack_d;
	logic [31:0]             rdata_q;
	logic [31:0]             rdata_d;
	logic [2:0]              enable_q;
	logic [2:0]              enable_d;
	logic                    irq_q;
	logic                    irq_d;

	logic                    take;
	logic                    wr_take;

	// Collect the bus request into one carrier
	always_comb begin
		req.rd    = avs_read_i;
		req.wr    = avs_write_i;
		req.addr  = avs_address_i;
		req.be    = avs_byteenable_i;
		req.wdata = avs_writedata_i;
	end

	// Read decode; unmapped offsets read as zero
	function automatic logic [31:0] reg_read(input logic [3:0] a,
		input logic [2:0] en, input logic [2:0] st,
		input logic [RSBIE_PTR_W-1:0] lv);
		logic [31:0] v;
		v = '0;
		unique case (a)
			RSBIE_OFS_ENABLE: v[2:0] = en;
			RSBIE_OFS_STATUS: v[2:0] = st;
			RSBIE_OFS_LEVEL:  v[RSBIE_PTR_W-1:0] = lv;
			default:          v = '0;
		endcase
		return v;
	endfunction : reg_read

	// Write hit test, honouring the low byte lane
	function automatic logic reg_hit(input rsbie_req_t r, input logic [3:0] ofs);
		return r.wr && (r.addr == ofs) && r.be[0];
	endfunction : reg_hit

	// Every request waits exactly one cycle; it completes on the second edge
	always_comb begin
		ack_d   = (req.rd || req.wr) && !ack_q;
		take    = (req.rd || req.wr) && ack_q;
		wr_take = take && req.wr;
		rdata_d = rdata_q;
		if ((req.rd || req.wr) && !ack_q) begin
			rdata_d = req.rd ? reg_read(req.addr, enable_q, sts, level) : '0;
		end
	end

	// Bus handshake registers
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_q   <= 1'b0;
			rdata_q <= RSBIE_RDATA_RST;
		end else begin
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	assign avs_waitrequest_o = (req.rd || req.wr) && !ack_q;
	assign avs_readdata_o    = rdata_q;

	// Enable register: one bit per interrupt, zero disables, one enables
	always_comb begin
		enable_d = enable_q;
		if (wr_take && reg_hit(req, RSBIE_OFS_ENABLE)) begin
			enable_d = req.wdata[2:0];
		end
	end

	// Enable storage, cleared at reset so all sources start disabled
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			enable_q <= RSBIE_ENABLE_RST;
		end else begin
			enable_q <= enable_d;
		end
	end

	// Write-one-to-clear strobes for the status register
	always_comb begin
		w1c = '0;
		if (wr_take && reg_hit(req, RSBIE_OFS_STATUS)) begin
			w1c = req.wdata[2:0];
		end
	end

	// Slip buffer on the receive path
	rsbie_slip_buf u_buf (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.wr_i      (line_wr_i),
		.wdata_i   (line_data_i),
		.rd_i      (sys_rd_i),
		.rdata_o   (sys_data_o),
		.level_o   (level),
		.evt_o     (evt)
	);

	// Status bits record slip events whether or not they are enabled
	rsbie_sticky u_sts (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.set_i     (evt),
		.clr_i     (w1c),
		.sts_o     (sts)
	);

	// Interrupt gating: a source counts only while its enable is one
	always_comb begin
		irq_d = |(sts & enable_q);
	end

	// Registered interrupt output
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	assign irq_o = irq_q;

	// Checks on the slip and interrupt behaviour
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_full_status_set: assert property (
		evt.full |=> sts[RSBIE_BIT_FULL])
		else $error("full status not set after frame drop");

	a_full_frame_drop: assert property (
		line_wr_i && !sys_rd_i && level == RSBIE_DEPTH
		|=> level == RSBIE_DEPTH - RSBIE_FRAME + 6'h01 && sts[RSBIE_BIT_FULL])
		else $error("write while full did not drop one frame");

	a_empty_status_set: assert property (
		evt.empty |=> sts[RSBIE_BIT_EMPTY])
		else $error("empty status not set after replay");

	a_empty_frame_replay: assert property (
		sys_rd_i && !line_wr_i && level == 6'h00
		|=> level == RSBIE_FRAME - 6'h01 && sts[RSBIE_BIT_EMPTY])
		else $error("read while empty did not replay one frame");

	a_slip_on_either: assert property (
		(evt.full || evt.empty) |=> sts[RSBIE_BIT_SLIP] ##1 sts[RSBIE_BIT_SLIP] || $past(w1c[0]))
		else $error("slip status missing after drop or replay");

	a_disabled_no_irq: assert property (
		enable_q == 3'h0 |=> !irq_o)
		else $error("interrupt raised with all enables off");

	a_enable_write_lands: assert property (
		wr_take && reg_hit(req, RSBIE_OFS_ENABLE)
		|=> enable_q == $past(avs_writedata_i[2:0]))
		else $error("enable write did not land");

	a_irq_follows_gate: assert property (
		|(sts & enable_q) |=> irq_o)
		else $error("enabled status did not raise interrupt");

	a_records_when_off: assert property (
		evt.full && enable_q == 3'h0 && enable_d == 3'h0 |=> sts[RSBIE_BIT_FULL] ##1 !irq_o)
		else $error("disabled status not recorded or leaked");

	a_bus_answer_time: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus answer later than one wait cycle");

	a_wait_only_busy: assert property (
		!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
		else $error("waitrequest raised with no request");

	// Sticky status: cleared only by a one, set only by an event
	a_clear_when_quiet: assert property (
		w1c[RSBIE_BIT_FULL] && !evt.full |=> !sts[RSBIE_BIT_FULL])
		else $error("full status not cleared by write of one");

	a_status_holds: assert property (
		sts[RSBIE_BIT_EMPTY] && !w1c[RSBIE_BIT_EMPTY] |=> sts[RSBIE_BIT_EMPTY])
		else $error("empty status dropped without a clear");

	a_status_no_spurious: assert property (
		!sts[RSBIE_BIT_SLIP] && !evt.slip |=> !sts[RSBIE_BIT_SLIP])
		else $error("slip status set without a drop or replay");

	a_slip_with_event: assert property (
		evt.slip == (evt.full || evt.empty))
		else $error("slip event not tied to drop or replay");

	// Enabled events reach the interrupt two cycles after they happen
	a_full_irq_path: assert property (
		evt.full && enable_q[RSBIE_BIT_FULL] && enable_d[RSBIE_BIT_FULL] |=> ##1 irq_o)
		else $error("enabled full event did not raise interrupt");

	a_empty_irq_path: assert property (
		evt.empty && enable_q[RSBIE_BIT_EMPTY] && enable_d[RSBIE_BIT_EMPTY] |=> ##1 irq_o)
		else $error("enabled empty event did not raise interrupt");

	a_slip_irq_path: assert property (
		evt.slip && enable_q[RSBIE_BIT_SLIP] && enable_d[RSBIE_BIT_SLIP] |=> ##1 irq_o)
		else $error("enabled slip event did not raise interrupt");

	a_irq_needs_source: assert property (
		!(|(sts & enable_q)) |=> !irq_o)
		else $error("interrupt raised with no enabled status");

	// Enable register only moves on a completed write with the low lane
	a_enable_lane_guard: assert property (
		wr_take && req.addr == RSBIE_OFS_ENABLE && !req.be[0] |=> $stable(enable_q))
		else $error("enable changed by write without low byte lane");

	a_enable_idle_hold: assert property (
		!wr_take |=> $stable(enable_q))
		else $error("enable changed without a bus write");

	// Read data is captured in the wait cycle and then stands
	a_read_enable_map: assert property (
		req.rd && !ack_q && req.addr == RSBIE_OFS_ENABLE |=> avs_readdata_o == {29'h0, $past(enable_q)})
		else $error("enable read returned wrong value");

	a_read_status_map: assert property (
		req.rd && !ack_q && req.addr == RSBIE_OFS_STATUS |=> avs_readdata_o == {29'h0, $past(sts)})
		else $error("status read returned wrong value");

	a_read_unmapped_zero: assert property (
		req.rd && !ack_q && req.addr != RSBIE_OFS_ENABLE && req.addr != RSBIE_OFS_STATUS
		&& req.addr != RSBIE_OFS_LEVEL |=> avs_readdata_o == 32'h0000_0000)
		else $error("unmapped read returned nonzero data");

	a_readdata_holds: assert property (
		!((req.rd || req.wr) && !ack_q) |=> $stable(avs_readdata_o))
		else $error("read data changed outside a wait cycle");

	// Buffer level bookkeeping away from the slip points
	a_level_in_range: assert property (
		level <= RSBIE_DEPTH)
		else $error("buffer level beyond two frames");

	a_plain_write_level: assert property (
		line_wr_i && !sys_rd_i && level != RSBIE_DEPTH |=> level == $past(level) + 6'h01)
		else $error("plain write did not add one byte");

	a_plain_read_level: assert property (
		sys_rd_i && !line_wr_i && level != 6'h00 |=> level == $past(level) - 6'h01)
		else $error("plain read did not remove one byte");

	a_both_level_kept: assert property (
		sys_rd_i && line_wr_i && level != 6'h00 |=> level == $past(level))
		else $error("read with write changed the level");

	c_frame_drop:  cover property (evt.full ##2 irq_o);
	c_frame_replay: cover property (evt.empty ##2 irq_o);
	c_both_strobes: cover property (sys_rd_i && line_wr_i);
	c_status_clear: cover property (w1c != 3'h0 && sts != 3'h0);
	c_enable_write: cover property (wr_take && reg_hit(req, RSBIE_OFS_ENABLE));

endmodule : rsbie_top

/* File: bench/test_rsbie_top.sv */
/*
 * Self-checking bench for rsbie_top: register bus traffic, slip buffer
 * overflow and underflow, and interrupt enables. Random data is seeded.
 * Assumes rsbie_pkg is compiled first and one 25 MHz clock.
 */
`timescale 1ns/1ns
module test_rsbie_top;
	import rsbie_pkg::*;

	logic                    sys_clk_i        = 1'b0;
	logic                    rst_n_i          = 1'b0;
	logic [3:0]              avs_address_i    = 4'h0;
	logic                    avs_read_i       = 1'b0;
	logic                    avs_write_i      = 1'b0;
	logic [31:0]             avs_writedata_i  = 32'h0;
	logic [3:0]              avs_byteenable_i = 4'h0;
	logic [31:0]             avs_readdata_o;
	logic                    avs_waitrequest_o;
	logic                    line_wr_i        = 1'b0;
	logic [RSBIE_DATA_W-1:0] line_data_i      = 8'h00;
	logic                    sys_rd_i         = 1'b0;
	logic [RSBIE_DATA_W-1:0] sys_data_o;
	logic                    irq_o;
	int                      fail_count       = 0;
	int                      samples_checked  = 0;
	logic [7:0]              seed             = 8'h0A;
	logic [7:0]              fifo_q[$];
	logic [7:0]              last_q[$];
	logic [2:0]              sts              = 3'h0;

	// Clock at 25 MHz
	always #20 sys_clk_i = ~sys_clk_i;

	rsbie_top rsbie_top_i (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.line_wr_i(line_wr_i), .line_data_i(line_data_i), .sys_rd_i(sys_rd_i),
		.sys_data_o(sys_data_o), .irq_o(irq_o));

	// Eight-bit LFSR for repeatable random values
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	// Expected interrupt level from enables and status
	function automatic logic irq_exp(input logic [2:0] en, input logic [2:0] st);
		return |(en & st);
	endfunction : irq_exp

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	// Verdict and end of run
	task automatic results();
		$display("checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	// One Avalon-MM transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		avs_address_i    <= a;
		avs_writedata_i  <= d;
		avs_byteenable_i <= be;
		avs_write_i      <= wr;
		avs_read_i       <= ~wr;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 16);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i  <= 1'b0;
		if (n >= 16)
			check(32'h1, 32'h0);
	endtask : bus

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] q;
		bus(1'b1, a, d, be, q);
	endtask : wr_reg

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, 4'hF, q);
		check(q, exp);
	endtask : rd_chk

	// Let the interrupt settle, then compare its level
	task automatic irq_chk(input logic e);
		repeat (3) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		check({31'h0, irq_o}, {31'h0, e});
	endtask : irq_chk

	// Back-to-back line writes; model drops the oldest frame when full
	task automatic push(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk_i);
			seed = lfsr(seed);
			line_wr_i   <= 1'b1;
			line_data_i <= seed;
			if (fifo_q.size() == int'(RSBIE_DEPTH)) begin
				repeat (int'(RSBIE_FRAME)) begin
					void'(fifo_q.pop_front());
				end
				sts |= 3'h5;
			end
			fifo_q.push_back(seed);
		end
		@(posedge sys_clk_i);
		line_wr_i <= 1'b0;
	endtask : push

	// Single reads; model replays the last frame read when empty
	task automatic pull(input int n);
		logic [7:0] b;
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk_i);
			sys_rd_i <= 1'b1;
			if (fifo_q.size() == 0) begin
				fifo_q = last_q;
				sts |= 3'h3;
			end
			b = fifo_q.pop_front();
			last_q.push_back(b);
			if (last_q.size() > int'(RSBIE_FRAME))
				void'(last_q.pop_front());
			@(posedge sys_clk_i);
			sys_rd_i <= 1'b0;
			@(negedge sys_clk_i);
			check({24'h0, sys_data_o}, {24'h0, b});
		end
	endtask : pull

	// Main sequence
	initial begin
		repeat (16) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		rd_chk(RSBIE_OFS_ENABLE, 32'h0);
		rd_chk(RSBIE_OFS_STATUS, 32'h0);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			wr_reg(RSBIE_OFS_ENABLE, {24'h0, seed}, 4'hF);
			rd_chk(RSBIE_OFS_ENABLE, {29'h0, seed[2:0]});
			irq_chk(1'b0);
		end
		wr_reg(RSBIE_OFS_ENABLE, {29'h0, ~seed[2:0]}, 4'hE);
		rd_chk(RSBIE_OFS_ENABLE, {29'h0, seed[2:0]});
		rd_chk(4'hC, 32'h0);
		wr_reg(RSBIE_OFS_ENABLE, 32'h0, 4'hF);
		push(int'(RSBIE_DEPTH));
		rd_chk(RSBIE_OFS_LEVEL, 32'd48);
		rd_chk(RSBIE_OFS_STATUS, 32'h0);
		push(1);
		rd_chk(RSBIE_OFS_LEVEL, 32'd25);
		rd_chk(RSBIE_OFS_STATUS, {29'h0, sts});
		irq_chk(1'b0);
		for (int e = 0; e < 8; e++) begin
			wr_reg(RSBIE_OFS_ENABLE, e, 4'hF);
			irq_chk(irq_exp(e[2:0], sts));
		end
		wr_reg(RSBIE_OFS_STATUS, 32'h5, 4'hF);
		sts = 3'h0;
		irq_chk(1'b0);
		pull(25);
		rd_chk(RSBIE_OFS_LEVEL, 32'h0);
		pull(1);
		rd_chk(RSBIE_OFS_LEVEL, 32'd23);
		rd_chk(RSBIE_OFS_STATUS, {29'h0, sts});
		wr_reg(RSBIE_OFS_ENABLE, 32'h2, 4'hF);
		irq_chk(1'b1);
		wr_reg(RSBIE_OFS_STATUS, 32'h2, 4'hF);
		sts = 3'h1;
		irq_chk(1'b0);
		wr_reg(RSBIE_OFS_ENABLE, 32'h1, 4'hF);
		irq_chk(1'b1);
		// Frame drop with the full interrupt enabled
		wr_reg(RSBIE_OFS_ENABLE, 32'h4, 4'hF);
		push(26);
		rd_chk(RSBIE_OFS_LEVEL, 32'd25);
		rd_chk(RSBIE_OFS_STATUS, {29'h0, sts});
		irq_chk(1'b1);
		// Line writes and system reads in the same cycles
		fork
			push(4);
			pull(2);
		join
		rd_chk(RSBIE_OFS_LEVEL, 32'd27);
		@(posedge sys_clk_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		rd_chk(RSBIE_OFS_ENABLE, 32'h0);
		irq_chk(1'b0);
		results();
	end

	// Watchdog well beyond the expected run length
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		fail_count++;
		results();
	end

endmodule : test_rsbie_top
